// [ccrg_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ccrg_params.svh"
module ccrg_host (
  input  wire logic clk_sys,
  input  wire logic rst,
  ccrg_if.host      pins,
  input  wire logic user_source_efi,
  input  wire logic user_align_req,
  input  wire logic user_channel_2,
  input  wire logic user_bus_ready,
  input  wire logic user_reset_req,
  input  wire logic user_sync_drive,
  input  wire logic user_sync_level,
  output logic      user_align_busy,
  output logic      user_ready,
  output logic      user_system_reset,
  output logic      user_cpu_clk
);
  ccrg_pkg::ccrg_cnt_t   efi_cnt_reg;
  ccrg_pkg::ccrg_cnt_t   xtal_cnt_reg;
  ccrg_pkg::ccrg_cnt_t   hold_cnt_reg;
  logic                  efi_reg;
  logic                  xtal_reg;
  logic                  efi_rise;
  logic                  efi_wrap;
  logic                  xtal_wrap;
  ccrg_pkg::ccrg_align_e state_reg;
  ccrg_pkg::ccrg_align_e state_next;
  logic                  align_reg;
  logic                  src_reg;
  logic                  en1_reg;
  logic                  en2_reg;
  logic                  bus_ready_in_1_reg;
  logic                  bus_ready_in_2_reg;
  logic                  clear_n_reg;
  logic                  sync_oe_reg;
  logic                  sync_out_reg;
  logic                  obs_ready_reg;
  logic                  obs_reset_reg;
  logic                  obs_clk_reg;
  logic                  busy_reg;

  ////////////////////////////////////////////////////////////////////////
  assign efi_wrap  = (efi_cnt_reg == `CCRG_EFI_HALF - `CCRG_HALF_ONE);
  assign xtal_wrap = (xtal_cnt_reg == `CCRG_XTAL_HALF - `CCRG_HALF_ONE);
  assign efi_rise  = efi_wrap & ~efi_reg;

  // align only with external source; RAISE and HOLD advance only with an efi rise
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ccrg_pkg::CCRG_ALIGN_IDLE: begin
        if (user_align_req && src_reg) begin
          state_next = ccrg_pkg::CCRG_ALIGN_RAISE;
        end
      end
      ccrg_pkg::CCRG_ALIGN_RAISE: begin
        if (efi_rise) begin
          state_next = ccrg_pkg::CCRG_ALIGN_HOLD;
        end
      end
      ccrg_pkg::CCRG_ALIGN_HOLD: begin
        if (efi_rise && hold_cnt_reg == `CCRG_ALIGN_PERIODS) begin
          state_next = ccrg_pkg::CCRG_ALIGN_DROP;
        end
      end
      ccrg_pkg::CCRG_ALIGN_DROP: begin
        state_next = ccrg_pkg::CCRG_ALIGN_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      efi_cnt_reg  <= 3'h0;
      xtal_cnt_reg <= 3'h0;
      efi_reg      <= 1'b0;
      xtal_reg     <= 1'b0;
    end else begin
      efi_cnt_reg  <= efi_wrap ? 3'h0 : efi_cnt_reg + `CCRG_HALF_ONE;
      xtal_cnt_reg <= xtal_wrap ? 3'h0 : xtal_cnt_reg + `CCRG_HALF_ONE;
      efi_reg      <= efi_wrap ? ~efi_reg : efi_reg;
      xtal_reg     <= xtal_wrap ? ~xtal_reg : xtal_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg    <= ccrg_pkg::CCRG_ALIGN_IDLE;
      busy_reg     <= 1'b0;
      hold_cnt_reg <= 3'h0;
      align_reg    <= 1'b0;
      src_reg      <= 1'b0;
    end else begin
      state_reg    <= state_next;
      busy_reg     <= (state_next != ccrg_pkg::CCRG_ALIGN_IDLE);
      hold_cnt_reg <= (state_reg != ccrg_pkg::CCRG_ALIGN_HOLD) ? 3'h0
                    : (efi_rise ? hold_cnt_reg + `CCRG_HALF_ONE : hold_cnt_reg);
      align_reg    <= efi_rise ? (state_reg == ccrg_pkg::CCRG_ALIGN_RAISE ||
                                  (state_reg == ccrg_pkg::CCRG_ALIGN_HOLD &&
                                   hold_cnt_reg != `CCRG_ALIGN_PERIODS)) : align_reg;
      src_reg      <= (state_reg == ccrg_pkg::CCRG_ALIGN_IDLE) ? user_source_efi : src_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      en1_reg       <= 1'b1;
      en2_reg       <= 1'b1;
      bus_ready_in_1_reg      <= 1'b0;
      bus_ready_in_2_reg      <= 1'b0;
      clear_n_reg   <= 1'b0;
      sync_oe_reg   <= 1'b0;
      sync_out_reg  <= 1'b1;
      obs_ready_reg <= 1'b0;
      obs_reset_reg <= 1'b1;
      obs_clk_reg   <= 1'b1;
    end else begin
      en1_reg       <= user_channel_2;
      en2_reg       <= ~user_channel_2;
      // idle channel shows the inverse, so the enable mask is exercised
      bus_ready_in_1_reg      <= user_bus_ready ^ user_channel_2;
      bus_ready_in_2_reg      <= user_bus_ready ^ ~user_channel_2;
      clear_n_reg   <= ~user_reset_req;
      sync_oe_reg   <= user_sync_drive;
      sync_out_reg  <= user_sync_level;
      obs_ready_reg <= pins.ready;
      obs_reset_reg <= pins.system_reset;
      obs_clk_reg   <= pins.cpu_clk;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign pins.crystal_osc_in        = xtal_reg;
  assign pins.external_frequency_in = efi_reg;
  assign pins.clock_source_select   = src_reg;
  assign pins.clock_phase_align     = align_reg;
  assign pins.bus_ready_in_1        = bus_ready_in_1_reg;
  assign pins.bus_ready_in_2        = bus_ready_in_2_reg;
  assign pins.bus_ready_enable_1    = en1_reg;
  assign pins.bus_ready_enable_2    = en2_reg;
  assign pins.power_on_clear_in     = clear_n_reg;
  assign pins.sync_select_oe        = sync_oe_reg;
  assign pins.sync_select_out       = sync_out_reg;
  assign user_align_busy            = busy_reg;
  assign user_ready                 = obs_ready_reg;
  assign user_system_reset          = obs_reset_reg;
  assign user_cpu_clk               = obs_clk_reg;
endmodule
`default_nettype wire

// [ccrg_params.svh]
`ifndef CCRG_PARAMS_SVH
`define CCRG_PARAMS_SVH

// divide counter: 0 is the high phase, 2 is the held value
`define CCRG_DIV_HIGH        2'h0
`define CCRG_DIV_LAST        2'h2
`define CCRG_DIV_ONE         2'h1

// host side oscillator half periods in clk_sys cycles
`define CCRG_EFI_HALF        3'h3
`define CCRG_XTAL_HALF       3'h4
`define CCRG_HALF_ONE        3'h1

// align pulse width in external frequency periods, less one
`define CCRG_ALIGN_PERIODS   3'h2

`endif

// [ccrg_pkg.sv]
package ccrg_pkg;

  typedef enum logic {
    CCRG_SRC_XTAL = 1'b0,
    CCRG_SRC_EFI  = 1'b1
  } ccrg_src_e;

  typedef enum logic {
    CCRG_SYNC_TWO = 1'b0,
    CCRG_SYNC_ONE = 1'b1
  } ccrg_sync_e;

  typedef enum logic [1:0] {
    CCRG_ALIGN_IDLE  = 2'b00,
    CCRG_ALIGN_RAISE = 2'b01,
    CCRG_ALIGN_HOLD  = 2'b10,
    CCRG_ALIGN_DROP  = 2'b11
  } ccrg_align_e;

  typedef logic [1:0] ccrg_div_t;
  typedef logic [2:0] ccrg_cnt_t;

endpackage

// [ccrg_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ccrg_if;
  logic crystal_osc_in;
  logic external_frequency_in;
  logic clock_source_select;
  logic clock_phase_align;
  logic bus_ready_in_1;
  logic bus_ready_in_2;
  logic bus_ready_enable_1;
  logic bus_ready_enable_2;
  logic power_on_clear_in;
  logic sync_select_out;
  logic sync_select_oe;
  wire  ready_sync_depth_select;
  logic crystal_tap_out;
  logic cpu_clk;
  logic peripheral_clk;
  logic ready;
  logic system_reset;

  // internal pull-up on the depth select pin
  assign ready_sync_depth_select = sync_select_oe ? sync_select_out : 1'b1;

  modport device (
    input  crystal_osc_in,
    input  external_frequency_in,
    input  clock_source_select,
    input  clock_phase_align,
    input  bus_ready_in_1,
    input  bus_ready_in_2,
    input  bus_ready_enable_1,
    input  bus_ready_enable_2,
    input  power_on_clear_in,
    input  ready_sync_depth_select,
    output crystal_tap_out,
    output cpu_clk,
    output peripheral_clk,
    output ready,
    output system_reset
  );

  modport host (
    output crystal_osc_in,
    output external_frequency_in,
    output clock_source_select,
    output clock_phase_align,
    output bus_ready_in_1,
    output bus_ready_in_2,
    output bus_ready_enable_1,
    output bus_ready_enable_2,
    output power_on_clear_in,
    output sync_select_out,
    output sync_select_oe,
    input  crystal_tap_out,
    input  cpu_clk,
    input  peripheral_clk,
    input  ready,
    input  system_reset
  );
endinterface
`default_nettype wire

// [ccrg_div3.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ccrg_params.svh"
module ccrg_div3 (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic src_rise,
  input  wire logic align,
  output logic      cpu_clk,
  output logic      pclk,
  output logic      clk_rise_ev,
  output logic      clk_fall_ev
);
  ccrg_pkg::ccrg_div_t count_reg;
  ccrg_pkg::ccrg_div_t count_next;
  ccrg_pkg::ccrg_div_t count_inc;
  logic                clk_reg;
  logic                clk_next;
  logic                pclk_reg;
  logic                pclk_next;

  ////////////////////////////////////////////////////////////////////////
  assign count_inc  = (count_reg == `CCRG_DIV_LAST) ? `CCRG_DIV_HIGH
                                                    : count_reg + `CCRG_DIV_ONE;
  assign count_next = align    ? `CCRG_DIV_LAST
                    : src_rise ? count_inc
                    : count_reg;
  // high for one source period of three
  assign clk_next   = align ? 1'b1 : (count_next == `CCRG_DIV_HIGH);
  assign clk_rise_ev = clk_next & ~clk_reg;
  assign clk_fall_ev = ~clk_next & clk_reg;
  // toggle on each cpu clock fall gives equal halves
  assign pclk_next  = align ? 1'b1 : (clk_fall_ev ? ~pclk_reg : pclk_reg);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_reg <= `CCRG_DIV_LAST;
      clk_reg   <= 1'b1;
      pclk_reg  <= 1'b1;
    end else begin
      count_reg <= count_next;
      clk_reg   <= clk_next;
      pclk_reg  <= pclk_next;
    end
  end

  assign cpu_clk = clk_reg;
  assign pclk    = pclk_reg;
endmodule
`default_nettype wire

// [ccrg_device.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ccrg_params.svh"
module ccrg_device (
  input  wire logic clk_sys,
  input  wire logic rst,
  ccrg_if.device    pins
);
  logic xtal_prev_reg;
  logic efi_prev_reg;
  logic tap_reg;
  logic src_level;
  logic src_prev;
  logic src_rise;
  logic use_efi;

  logic cpu_clk;
  logic pclk;
  logic clk_rise_ev;
  logic clk_fall_ev;

  logic ready_raw;
  logic ready_ch1;
  logic ready_ch2;
  logic two_stage;
  logic stage1_reg;
  logic stage1_next;
  logic stage2_reg;
  logic stage2_next;
  logic stage2_in;

  logic reset_reg;
  logic reset_next;
  logic reset_req;

  ////////////////////////////////////////////////////////////////////////
  // source selection and input clock edge detection

  assign use_efi   = (pins.clock_source_select == ccrg_pkg::CCRG_SRC_EFI);
  assign src_level = use_efi ? pins.external_frequency_in
                             : pins.crystal_osc_in;
  assign src_prev  = use_efi ? efi_prev_reg
                             : xtal_prev_reg;
  assign src_rise  = src_level & ~src_prev;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      xtal_prev_reg <= 1'b0;
      efi_prev_reg  <= 1'b0;
    end else begin
      xtal_prev_reg <= pins.crystal_osc_in;
      efi_prev_reg  <= pins.external_frequency_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // crystal output runs regardless of the source select

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tap_reg <= 1'b0;
    end else begin
      tap_reg <= pins.crystal_osc_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // divide by three and peripheral clock

  ccrg_div3 u_div3 (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .src_rise    (src_rise),
    .align       (pins.clock_phase_align),
    .cpu_clk     (cpu_clk),
    .pclk        (pclk),
    .clk_rise_ev (clk_rise_ev),
    .clk_fall_ev (clk_fall_ev)
  );

  ////////////////////////////////////////////////////////////////////////
  // ready qualification

  assign ready_ch1 = pins.bus_ready_in_1 & ~pins.bus_ready_enable_1;
  assign ready_ch2 = pins.bus_ready_in_2 & ~pins.bus_ready_enable_2;
  assign ready_raw = ready_ch1 | ready_ch2;

  assign two_stage = (pins.ready_sync_depth_select == ccrg_pkg::CCRG_SYNC_TWO);

  ////////////////////////////////////////////////////////////////////////
  // ready synchroniser on cpu clock edges

  // first stage samples on the cpu clock rise
  assign stage1_next = clk_rise_ev ? ready_raw : stage1_reg;

  // second stage: with two stages a rise must have passed the first stage, a fall goes straight in
  assign stage2_in   = two_stage ? (stage1_reg & ready_raw)
                                 : ready_raw;
  // updating only at the cpu clock fall keeps the cpu hold time
  assign stage2_next = clk_fall_ev ? stage2_in : stage2_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset output

  assign reset_req  = ~pins.power_on_clear_in;
  assign reset_next = clk_fall_ev ? reset_req : reset_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reset_reg <= 1'b1;
    end else begin
      reset_reg <= reset_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin outputs, each from a flop

  assign pins.crystal_tap_out = tap_reg;
  assign pins.cpu_clk         = cpu_clk;
  assign pins.peripheral_clk  = pclk;
  assign pins.ready           = stage2_reg;
  assign pins.system_reset    = reset_reg;
endmodule
`default_nettype wire

// [ccrg_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module ccrg_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic crystal_osc_in,
  input wire logic clock_source_select,
  input wire logic clock_phase_align,
  input wire logic bus_ready_in_1,
  input wire logic bus_ready_in_2,
  input wire logic bus_ready_enable_1,
  input wire logic bus_ready_enable_2,
  input wire logic power_on_clear_in,
  input wire logic ready_sync_depth_select,
  input wire logic crystal_tap_out,
  input wire logic cpu_clk,
  input wire logic peripheral_clk,
  input wire logic ready,
  input wire logic system_reset
);
  logic raw;
  logic raw_q;
  logic cpu_q;
  logic src_q;
  logic s1_reg;
  logic src_chg;
  assign raw = (bus_ready_in_1 & ~bus_ready_enable_1) | (bus_ready_in_2 & ~bus_ready_enable_2);
  assign src_chg = src_q != clock_source_select;
  always_ff @(posedge clk_sys) begin
    raw_q <= raw;
    cpu_q <= cpu_clk;
    src_q <= clock_source_select;
  end
  // first stage copy, taken when the cpu clock rises
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_reg <= 1'b0;
    end else if (cpu_clk && !cpu_q) begin
      s1_reg <= raw_q;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst || src_chg);
  ////////////////////////////////////////////////////////////////////////////////
  a_align_hold: assert property (clock_phase_align |=> cpu_clk && peripheral_clk)
    else $error("clocks not held high under align");
  a_align_restart: assert property ($fell(clock_phase_align) && clock_source_select |->
    cpu_clk[*7] ##1 !cpu_clk) else $error("divider did not restart");
  a_high_efi: assert property (disable iff (rst || src_chg || clock_phase_align)
    $rose(cpu_clk) && clock_source_select |-> cpu_clk[*6] ##1 !cpu_clk)
    else $error("cpu clock high time wrong on external source");
  a_high_xtal: assert property (disable iff (rst || src_chg || clock_phase_align)
    $rose(cpu_clk) && !clock_source_select |-> cpu_clk[*8] ##1 !cpu_clk)
    else $error("cpu clock high time wrong on crystal");
  a_low_efi: assert property (disable iff (rst || src_chg || clock_phase_align)
    $fell(cpu_clk) && clock_source_select |-> !cpu_clk[*8] ##1 !cpu_clk[*4] ##1 cpu_clk)
    else $error("cpu clock low time wrong");
  a_pclk_at_fall: assert property ($changed(peripheral_clk) && !$past(clock_phase_align)
    |-> $fell(cpu_clk)) else $error("peripheral clock moved off a cpu fall");
  a_pclk_toggles: assert property ($fell(cpu_clk) |-> $changed(peripheral_clk))
    else $error("peripheral clock missed a toggle");
  a_ready_edge: assert property ($changed(ready) |-> $fell(cpu_clk))
    else $error("ready changed off a cpu fall");
  a_ready_one: assert property (
    $fell(cpu_clk) && $past(ready_sync_depth_select) |-> ready == $past(raw))
    else $error("single stage ready wrong");
  a_ready_two: assert property ($fell(cpu_clk) && !$past(ready_sync_depth_select)
    |-> ready == ($past(raw) && s1_reg)) else $error("two stage ready wrong");
  a_reset_out: assert property ($fell(cpu_clk) |->
    system_reset == !$past(power_on_clear_in))
    else $error("system reset not inverse of request");
  a_reset_edge: assert property ($changed(system_reset) |-> $fell(cpu_clk))
    else $error("system reset changed off a cpu fall");
  a_tap_copy: assert property (!$past(rst) |-> crystal_tap_out == $past(crystal_osc_in))
    else $error("crystal tap is not the oscillator");
  c_align: cover property ($fell(clock_phase_align));
  c_rdy_two: cover property ($rose(ready) && !ready_sync_depth_select);
  c_rdy_one: cover property ($rose(ready) && ready_sync_depth_select);
  c_reset_out: cover property ($fell(system_reset));
endmodule
`default_nettype wire

// [cpu_clock_ready_reset_gen_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fails++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module cpu_clock_ready_reset_gen_bench;
  typedef struct {logic ch2; logic rdy; logic drv; logic lvl;
                  logic rq; logic er; logic es;} ccrg_row_s;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic u_src = 1'b0;
  logic u_align = 1'b0;
  logic u_ch2 = 1'b0;
  logic u_rdy = 1'b0;
  logic u_rq = 1'b0;
  logic u_drv = 1'b0;
  logic u_lvl = 1'b0;
  logic u_busy;
  logic u_ready;
  logic u_sysrst;
  logic u_cpu;
  int fails = 0;
  int check_count = 0;
  int hi;
  int per;
  ccrg_row_s rows [6] = '{'{0, 1, 1, 0, 0, 1, 0}, '{0, 0, 1, 0, 1, 0, 1}, '{1, 1, 0, 0, 0, 1, 0},
                          '{1, 0, 1, 1, 1, 0, 1}, '{0, 1, 1, 1, 0, 1, 0}, '{1, 1, 1, 0, 1, 1, 1}};
  always #2.5 clk_sys = ~clk_sys;
  ccrg_if bus ();
  ccrg_device i_ccrg_device (.clk_sys(clk_sys), .rst(rst), .pins(bus.device));
  ccrg_host i_ccrg_host (.clk_sys(clk_sys), .rst(rst), .pins(bus.host), .user_source_efi(u_src),
    .user_align_req(u_align), .user_channel_2(u_ch2), .user_bus_ready(u_rdy),
    .user_reset_req(u_rq), .user_sync_drive(u_drv), .user_sync_level(u_lvl),
    .user_align_busy(u_busy), .user_ready(u_ready), .user_system_reset(u_sysrst),
    .user_cpu_clk(u_cpu));
  ccrg_chk i_ccrg_chk (.clk_sys(clk_sys), .rst(rst), .crystal_osc_in(bus.crystal_osc_in),
    .clock_source_select(bus.clock_source_select), .clock_phase_align(bus.clock_phase_align),
    .bus_ready_in_1(bus.bus_ready_in_1), .bus_ready_in_2(bus.bus_ready_in_2),
    .bus_ready_enable_1(bus.bus_ready_enable_1), .bus_ready_enable_2(bus.bus_ready_enable_2),
    .power_on_clear_in(bus.power_on_clear_in),
    .ready_sync_depth_select(bus.ready_sync_depth_select), .crystal_tap_out(bus.crystal_tap_out),
    .cpu_clk(bus.cpu_clk), .peripheral_clk(bus.peripheral_clk), .ready(bus.ready),
    .system_reset(bus.system_reset));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // measures high time and period of cpu clock or peripheral clock
  task automatic measure(input bit use_p, output int h, output int p);
    int n;
    n = 0;
    h = 0;
    p = 0;
    while ((use_p ? bus.peripheral_clk : bus.cpu_clk) !== 1'b0 && n < 300) begin tick(1); n++; end
    while ((use_p ? bus.peripheral_clk : bus.cpu_clk) !== 1'b1 && n < 300) begin tick(1); n++; end
    while ((use_p ? bus.peripheral_clk : bus.cpu_clk) === 1'b1 && n < 300) begin
      tick(1); n++; h++; p++;
    end
    while ((use_p ? bus.peripheral_clk : bus.cpu_clk) === 1'b0 && n < 300) begin
      tick(1); n++; p++;
    end
    if (n >= 300) begin
      fails++;
      summarize();
    end
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (u_busy !== lvl && n < 200) begin tick(1); n++; end
    if (n >= 200) begin
      fails++;
      summarize();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(19);
    `CHK("reset sysrst", 1'b1, u_sysrst)
    `CHK("reset ready", 1'b0, u_ready)
    @(posedge clk_sys);
    rst <= 1'b0;
    tick(60);
    measure(0, hi, per);
    `CHK("xtal high", 8, hi)
    `CHK("xtal period", 24, per)
    measure(1, hi, per);
    `CHK("xtal pclk high", 24, hi)
    @(posedge clk_sys);
    u_align <= 1'b1;
    tick(12);
    `CHK("align refused", 1'b0, u_busy)
    @(posedge clk_sys);
    u_align <= 1'b0;
    u_src <= 1'b1;
    tick(60);
    measure(0, hi, per);
    `CHK("efi high", 6, hi)
    `CHK("efi period", 18, per)
    `CHK("cpu echo low", 1'b0, u_cpu)
    tick(1);
    `CHK("cpu echo high", 1'b1, u_cpu)
    measure(1, hi, per);
    `CHK("pclk high", 18, hi)
    `CHK("pclk period", 36, per)
    foreach (rows[i]) begin
      @(posedge clk_sys);
      u_ch2 <= rows[i].ch2;
      u_rdy <= rows[i].rdy;
      u_drv <= rows[i].drv;
      u_lvl <= rows[i].lvl;
      u_rq <= rows[i].rq;
      tick(60);
      `CHK("ready", rows[i].er, u_ready)
      `CHK("sysrst", rows[i].es, u_sysrst)
    end
    @(posedge clk_sys);
    u_align <= 1'b1;
    wait_busy(1'b1);
    @(posedge clk_sys);
    u_align <= 1'b0;
    wait_busy(1'b0);
    hi = 0;
    while (bus.cpu_clk === 1'b1 && hi < 300) begin
      tick(1);
      hi++;
    end
    `CHK("align restart high", 6, hi)
    measure(0, hi, per);
    `CHK("align high", 6, hi)
    `CHK("align period", 18, per)
    @(posedge clk_sys);
    rst <= 1'b1;
    tick(20);
    `CHK("rerst sysrst", 1'b1, u_sysrst)
    `CHK("rerst ready", 1'b0, u_ready)
    summarize();
  end
endmodule
`default_nettype wire
